//--- logic/pvd_bank.sv
// Eight peak value detection units with an APB register slave.
// Assumes sample strobes synchronous to i_clk, one 32-bit APB master.
//
// Our own choices: the APB register port and the register addresses.

// Behaviour
// RULE_01 - eight independent units, each with own output
// RULE_02 - each tracks min or max of one of four
// RULE_03 - run mode refreshes extreme on every sample
// RULE_04 - hold mode freezes last captured extreme
// RULE_05 - tracking output is stored extreme, not raw input
// RULE_06 - follow mode outputs the current selected sample
// RULE_07 - only run, hold, follow; both min and max
// RULE_08 - output samples at most 4800 Hz
// RULE_09 - host keeps unit rate below input rate
// RULE_10 - extremes cleared only by host restart command
// RULE_11 - unit outputs skip output filters
// RULE_12 - selector picks only the four analog inputs
// RULE_13 - reset configuration runs without any host
// RULE_14 - each result usable as routed virtual signal
// RULE_15 - after restart, next sample reloads the extreme
module pvd_bank
  import pvd_pkg::*;
#(
  parameter int RATE_MIN = RATE_MIN_CYC
) (
  // Clock, reset, enable
  input  wire logic                            i_clk,
  input  wire logic                            i_rst_n,
  input  wire logic                            i_ce,
  // Analog input sample stream
  input  wire pvd_smp_t                        i_smp,
  // APB slave
  input  wire pvd_apb_req_t                    i_apb,
  output logic [31:0]                          o_prdata,
  output logic                                 o_pready,
  output logic                                 o_pslverr,
  // Virtual signals
  output logic [NUM_UNITS-1:0][SMP_W-1:0]      o_unit_data,
  output logic [NUM_UNITS-1:0]                 o_unit_vld
);

  // ****************************************
  // Constants and helpers
  // ****************************************
  localparam logic [DIV_W-1:0] MIN_DIV = DIV_W'(RATE_MIN);

  // Power-up state: unit u watches channel u mod 4, low half max, high half min
  function automatic pvd_st_t rst_state();
    pvd_st_t st;
    st = '0;
    for (int u = 0; u < NUM_UNITS; u++) begin
      st.cfg[u].chan      = 2'(u % NUM_CHANS);
      st.cfg[u].track_max = (u < NUM_UNITS / 2);
      st.cfg[u].mode      = PVD_RUN;
      st.div[u]           = MIN_DIV;
      st.fresh[u]         = 1'b1;
    end
    return st;
  endfunction

  localparam pvd_st_t ST_RST = rst_state();

  // Signed compare toward the tracked extreme
  function automatic logic beats(input logic [SMP_W-1:0] s, input logic [SMP_W-1:0] p,
                                 input logic is_max);
    beats = is_max ? ($signed(s) > $signed(p)) : ($signed(s) < $signed(p));
  endfunction

  // Divisor never below the least output period
  function automatic logic [DIV_W-1:0] eff_div(input logic [DIV_W-1:0] dv);
    eff_div = (dv < MIN_DIV) ? MIN_DIV : dv;
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    if (a[1:0] != 2'b00) begin
      addr_hit = 1'b0;
    end else if (a[7:5] == CFG_BASE[7:5] || a[7:5] == RATE_BASE[7:5]) begin
      addr_hit = 1'b1;
    end else if (a[7:5] == RESULT_BASE[7:5]) begin
      addr_hit = 1'b1;
    end else if (a == RESTART_OFF || a == FRESH_OFF) begin
      addr_hit = 1'b1;
    end else begin
      addr_hit = 1'b0;
    end
  endfunction

  function automatic logic [31:0] rd_word(input pvd_st_t st, input logic [7:0] a);
    logic [2:0] u;
    u = a[4:2];
    if (a[1:0] != 2'b00) begin
      rd_word = '0;
    end else if (a[7:5] == CFG_BASE[7:5]) begin
      rd_word = 32'(st.cfg[u]);
    end else if (a[7:5] == RATE_BASE[7:5]) begin
      rd_word = 32'(st.div[u]);
    end else if (a[7:5] == RESULT_BASE[7:5]) begin
      rd_word = 32'(st.peak[u]);
    end else if (a == FRESH_OFF) begin
      rd_word = 32'(st.fresh);
    end else begin
      rd_word = '0; // Restart register reads as zero
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  pvd_st_t q;
  pvd_st_t d;

  // ****************************************
  // Next-state logic
  // ****************************************
  // Writes land only on the completing APB edge, so a restart and a
  // sample in the same cycle let the restart win: the sample is dropped.
  always_comb begin
    pvd_cfg_t           c;
    logic [SMP_W-1:0]   s;
    logic               v;
    logic               wr;
    logic [NUM_UNITS-1:0] restart;
    logic [2:0]         wu;
    c       = '0;
    s       = '0;
    v       = 1'b0;
    d       = q;
    wr      = i_apb.psel && i_apb.penable && q.pready && i_apb.pwrite && !q.pslverr;
    wu      = i_apb.paddr[4:2];
    restart = '0;
    if (i_ce) begin
      d.pready  = 1'b0;
      d.pslverr = 1'b0;
      d.out_vld = '0;
      // Setup phase prepares the answer for the access phase
      if (i_apb.psel && !i_apb.penable) begin
        d.pready  = 1'b1;
        d.pslverr = !addr_hit(i_apb.paddr);
        d.prdata  = rd_word(q, i_apb.paddr);
      end
      // Register writes
      if (wr) begin
        if (i_apb.paddr[7:5] == CFG_BASE[7:5]) begin
          d.cfg[wu].chan      = i_apb.pwdata[CFG_CHAN_LSB +: 2]; // RULE_12
          d.cfg[wu].track_max = i_apb.pwdata[CFG_MAX_BIT];     // RULE_02
          // The unused mode code is ignored, keeping the old mode
          if (i_apb.pwdata[CFG_MODE_LSB +: 2] != 2'b11) begin
            d.cfg[wu].mode = pvd_mode_t'(i_apb.pwdata[CFG_MODE_LSB +: 2]); // RULE_07
          end
        end else if (i_apb.paddr[7:5] == RATE_BASE[7:5]) begin
          d.div[wu] = i_apb.pwdata[DIV_W-1:0];
        end else if (i_apb.paddr == RESTART_OFF) begin
          restart = i_apb.pwdata[NUM_UNITS-1:0]; // RULE_10
        end
      end
      // Units work side by side with no shared state
      for (int u = 0; u < NUM_UNITS; u++) begin // RULE_01
        c = q.cfg[u];
        s = i_smp.data[c.chan]; // RULE_12
        v = i_smp.vld[c.chan];
        if (restart[u]) begin
          d.peak[u]  = '0;   // RULE_10
          d.fresh[u] = 1'b1; // RULE_15
        end else if (v) begin
          case (c.mode)
            PVD_RUN: begin
              // First sample after restart reloads, later ones compete
              if (q.fresh[u] || beats(s, q.peak[u], c.track_max)) begin // RULE_03 RULE_15
                d.peak[u] = s;
              end
              d.fresh[u] = 1'b0;
            end
            PVD_HOLD: begin
              d.peak[u] = q.peak[u]; // RULE_04
            end
            PVD_FOLLOW: begin
              d.peak[u]  = s;    // RULE_06
              d.fresh[u] = 1'b1; // Tracking resumes from present level
            end
            default: begin
              d.peak[u] = q.peak[u];
            end
          endcase
        end
        // Output pacing; raw extreme, no output filter in the path
        if (q.cnt[u] == '0) begin
          d.cnt[u]     = eff_div(q.div[u]) - 1'b1; // RULE_08
          d.out[u]     = q.peak[u];                // RULE_05 RULE_11
          d.out_vld[u] = 1'b1;                     // RULE_14
        end else begin
          d.cnt[u] = q.cnt[u] - 1'b1;
        end
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Config resets to a working setup, so no host is needed to run
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= ST_RST; // RULE_13
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state flops
  assign o_prdata    = q.prdata;
  assign o_pready    = q.pready;
  assign o_pslverr   = q.pslverr;
  assign o_unit_data = q.out;
  assign o_unit_vld  = q.out_vld;

  // ****************************************
  // Checks
  // ****************************************
  logic [SMP_W-1:0] smp0;
  logic             vld0;
  logic             apb_wr;
  logic             rst0;
  logic [DIV_W-1:0] gap0_q;

  assign smp0   = i_smp.data[q.cfg[0].chan];
  assign vld0   = i_smp.vld[q.cfg[0].chan];
  assign apb_wr = i_apb.psel && i_apb.penable && q.pready && i_apb.pwrite && !q.pslverr;
  assign rst0   = apb_wr && i_apb.paddr == RESTART_OFF && i_apb.pwdata[0];

  // Enabled cycles since unit 0 last produced; zero until its first pulse,
  // so the pulse right after reset is not taken for a short period
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap0_q <= '0;
    end else if (i_ce) begin
      if (o_unit_vld[0]) begin
        gap0_q <= DIV_W'(1);
      end else if (gap0_q != '0) begin
        gap0_q <= gap0_q + 1'b1;
      end
    end
  end

  // A strobe held by a low enable is seen once, at the next enabled edge
  property p_rate;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && o_unit_vld[0] && gap0_q != '0) |-> gap0_q >= MIN_DIV;
  endproperty
  a_rate: assert property (p_rate) else $error("unit 0 output faster than limit"); // RULE_08

  property p_run_max;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && q.cfg[0].mode == PVD_RUN && q.cfg[0].track_max && vld0 && !rst0
       && !q.fresh[0] && $signed(smp0) > $signed(q.peak[0])) |=> q.peak[0] == $past(smp0);
  endproperty
  a_run_max: assert property (p_run_max) else $error("run max missed a new peak"); // RULE_03

  property p_run_min;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && q.cfg[0].mode == PVD_RUN && !q.cfg[0].track_max && vld0 && !rst0
       && !q.fresh[0] && $signed(smp0) >= $signed(q.peak[0])) |=> $stable(q.peak[0]);
  endproperty
  a_run_min: assert property (p_run_min) else $error("run min took a larger sample"); // RULE_02

  property p_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      (q.cfg[0].mode == PVD_HOLD && !rst0) |=> $stable(q.peak[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("held peak changed"); // RULE_04

  property p_follow;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && q.cfg[0].mode == PVD_FOLLOW && vld0 && !rst0) |=> q.peak[0] == $past(smp0);
  endproperty
  a_follow: assert property (p_follow) else $error("follow did not pass sample"); // RULE_06

  property p_restart;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && rst0) |=> (q.peak[0] == '0 && q.fresh[0]);
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear unit 0"); // RULE_10

  property p_reload;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && q.cfg[0].mode == PVD_RUN && q.fresh[0] && vld0 && !rst0)
      |=> (q.peak[0] == $past(smp0) && !q.fresh[0]);
  endproperty
  a_reload: assert property (p_reload) else $error("restart reload missed"); // RULE_15

  property p_out;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_unit_vld[0] |-> o_unit_data[0] == $past(q.peak[0]);
  endproperty
  a_out: assert property (p_out) else $error("output is not the stored value"); // RULE_05

  property p_mode;
    @(posedge i_clk) disable iff (!i_rst_n)
      q.cfg[0].mode != pvd_mode_t'(2'b11);
  endproperty
  a_mode: assert property (p_mode) else $error("illegal mode stored"); // RULE_07

  property p_ready;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && i_apb.psel && !i_apb.penable) |=> o_pready;
  endproperty
  a_ready: assert property (p_ready) else $error("apb answer late");

  property p_cfg;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && apb_wr && i_apb.paddr == CFG_BASE) |=> (q.cfg[0].chan == $past(i_apb.pwdata[1:0])
       && q.cfg[0].track_max == $past(i_apb.pwdata[CFG_MAX_BIT]));
  endproperty
  a_cfg: assert property (p_cfg) else $error("unit 0 config write lost"); // RULE_02

  property p_keep;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !vld0 && !rst0) |=> $stable(q.peak[0]);
  endproperty
  a_keep: assert property (p_keep) else $error("peak changed with no sample or restart"); // RULE_10

  property p_misalign;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && i_apb.psel && !i_apb.penable && i_apb.paddr[1:0] != 2'b00) |=> o_pslverr;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned access not refused");

  property p_freeze;
    @(posedge i_clk) disable iff (!i_rst_n)
      !i_ce |=> $stable(q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low");

  property p_follow_fresh;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && q.cfg[0].mode == PVD_FOLLOW && vld0 && !rst0) |=> q.fresh[0];
  endproperty
  a_follow_fresh: assert property (p_follow_fresh) else $error("follow left reload off"); // RULE_15

  property p_ready_once;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !(i_apb.psel && !i_apb.penable)) |=> !o_pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("apb answer outside access");

  property p_rd_result;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && i_apb.psel && !i_apb.penable && i_apb.paddr == RESULT_BASE)
      |=> (!o_pslverr && o_prdata == 32'($past(q.peak[0])));
  endproperty
  a_rd_result: assert property (p_rd_result) else $error("result read wrong"); // RULE_14

endmodule

//--- logic/pvd_pkg.sv
// Package for the peak value detector bank: constants, field layouts and carriers.
// Assumes a single 200 MHz sample-path clock and APB register access.
package pvd_pkg;

  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam int NUM_UNITS    = 8;
  localparam int NUM_CHANS    = 4;
  localparam int SMP_W        = 16;
  localparam int DIV_W        = 20;
  localparam int CLK_HZ       = 200_000_000;
  localparam int OUT_RATE_HZ  = 4800;
  // Least output period, rounded up to whole cycles
  localparam int RATE_MIN_CYC = (CLK_HZ + OUT_RATE_HZ - 1) / OUT_RATE_HZ;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CFG_BASE    = 8'h00;
  localparam logic [7:0] RATE_BASE   = 8'h20;
  localparam logic [7:0] RESULT_BASE = 8'h40;
  localparam logic [7:0] RESTART_OFF = 8'h60;
  localparam logic [7:0] FRESH_OFF   = 8'h64;

  // Config field positions
  localparam int CFG_CHAN_LSB = 0;
  localparam int CFG_MAX_BIT  = 2;
  localparam int CFG_MODE_LSB = 3;
  localparam int CFG_W        = 5;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PVD_RUN,
    PVD_HOLD,
    PVD_FOLLOW
  } pvd_mode_t;

  typedef struct packed {
    pvd_mode_t  mode;
    logic       track_max;
    logic [1:0] chan;
  } pvd_cfg_t;

  typedef struct packed {
    logic                              psel;
    logic                              penable;
    logic                              pwrite;
    logic [7:0]                        paddr;
    logic [31:0]                       pwdata;
  } pvd_apb_req_t;

  typedef struct packed {
    logic [NUM_CHANS-1:0]              vld;
    logic [NUM_CHANS-1:0][SMP_W-1:0]   data;
  } pvd_smp_t;

  typedef struct packed {
    pvd_cfg_t [NUM_UNITS-1:0]          cfg;
    logic [NUM_UNITS-1:0][DIV_W-1:0]   div;
    logic [NUM_UNITS-1:0][DIV_W-1:0]   cnt;
    logic [NUM_UNITS-1:0][SMP_W-1:0]   peak;
    logic [NUM_UNITS-1:0]              fresh;
    logic [NUM_UNITS-1:0][SMP_W-1:0]   out;
    logic [NUM_UNITS-1:0]              out_vld;
    logic [31:0]                       prdata;
    logic                              pready;
    logic                              pslverr;
  } pvd_st_t;

endpackage

//--- test/pvd_src.sv
// Sample source model for the peak value detector bank.
// Assumes the bench calls send() from one process at a time.
module pvd_src
  import pvd_pkg::*;
(
  // Clock
  input  wire logic i_clk,
  // Sample stream toward the bank
  output pvd_smp_t  o_smp
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Driver
  // ****************************************
  initial o_smp = '0;

  // One-cycle strobe, then the line shows the inverse so a stale value never counts
  task automatic send(input int ch, input logic [SMP_W-1:0] v);
    @(posedge i_clk);
    o_smp.vld[ch]  <= 1'b1;
    o_smp.data[ch] <= v;
    @(posedge i_clk);
    o_smp.vld[ch]  <= 1'b0;
    o_smp.data[ch] <= ~v;
  endtask
endmodule

//--- test/peak_value_detector_bank_tb.sv
// Self-checking bench for the peak value detector bank.
// Assumes one APB master here and the sample source model beside it.
module peak_value_detector_bank_tb;
  import pvd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int RMIN = 8; // Short period keeps the run brief
  logic                            i_clk;
  logic                            i_rst_n;
  logic                            i_ce;
  pvd_smp_t                        smp;
  pvd_apb_req_t                    apb;
  logic [31:0]                     prdata;
  logic                            pready;
  logic                            pslverr;
  logic [NUM_UNITS-1:0][SMP_W-1:0] udata;
  logic [NUM_UNITS-1:0]            uvld;
  logic [31:0]                     rd;
  logic                            err;
  int                              mismatches = 0;
  int                              samples_checked = 0;
  int                              cyc = 0;
  int                              per;

  pvd_bank #(.RATE_MIN(RMIN)) u_pvd_bank (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_smp(smp), .i_apb(apb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_unit_data(udata), .o_unit_vld(uvld)
  );
  pvd_src u_pvd_src (.i_clk(i_clk), .o_smp(smp));

  // Clock at 200 MHz
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic wrap_up();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Setup, then access held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge i_clk);
    apb.penable <= 1'b1;
    forever begin
      @(posedge i_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    apb <= '0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  // Edges between two strobes of one unit
  task automatic period(input int u);
    @(posedge i_clk);
    while (uvld[u] !== 1'b1) @(posedge i_clk);
    per = 0;
    do begin
      @(posedge i_clk);
      per++;
    end while (uvld[u] !== 1'b1);
  endtask

  // Hang guard, well above the expected run length
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    apb = '0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    #1 check("vld_first", {24'h0, uvld}, 32'hFF);
    for (int u = 0; u < NUM_UNITS; u++) begin
      rdchk("cfg_dflt", CFG_BASE + 8'(4 * u), 32'((u < 4) ? 4 + u % 4 : u % 4));
    end
    rdchk("fresh_dflt", FRESH_OFF, 32'hFF);
    // Max and min side by side on channel 0, signed low value last
    u_pvd_src.send(0, 16'h0064);
    u_pvd_src.send(0, 16'h0032);
    u_pvd_src.send(0, 16'h00C8);
    u_pvd_src.send(0, 16'hFFFB);
    rdchk("run_max", RESULT_BASE, 32'hC8);
    rdchk("run_min", RESULT_BASE + 8'h10, 32'hFFFB);
    // Hold keeps the old peak though a larger sample arrives
    xfer(1'b1, CFG_BASE, 32'h0C);
    u_pvd_src.send(0, 16'h012C);
    rdchk("hold", RESULT_BASE, 32'hC8);
    // Follow returns the latest sample, even a smaller one
    xfer(1'b1, CFG_BASE + 8'h04, 32'h15);
    u_pvd_src.send(1, 16'h0007);
    u_pvd_src.send(1, 16'h0003);
    rdchk("follow", RESULT_BASE + 8'h04, 32'h3);
    xfer(1'b1, CFG_BASE + 8'h04, 32'h1E);
    rdchk("mode_bad", CFG_BASE + 8'h04, 32'h16);
    // Writes to a result place change nothing
    xfer(1'b1, RESULT_BASE, 32'h55);
    rdchk("result_ro", RESULT_BASE, 32'hC8);
    // Restart of unit 0 only, then reload from a smaller sample
    xfer(1'b1, RESTART_OFF, 32'h1);
    rdchk("cleared", RESULT_BASE, 32'h0);
    rdchk("indep", RESULT_BASE + 8'h10, 32'hFFFB);
    xfer(1'b0, FRESH_OFF, 32'h0);
    check("fresh_set", 32'(rd[0]), 32'h1);
    xfer(1'b1, CFG_BASE, 32'h04);
    u_pvd_src.send(0, 16'h000A);
    rdchk("reload", RESULT_BASE, 32'hA);
    xfer(1'b0, FRESH_OFF, 32'h0);
    check("fresh_clr", 32'(rd[0]), 32'h0);
    // Enable low: a larger sample is lost and the peak stays
    i_ce <= 1'b0;
    u_pvd_src.send(0, 16'h0050);
    i_ce <= 1'b1;
    rdchk("ce_freeze", RESULT_BASE, 32'hA);
    rdchk("restart_wo", RESTART_OFF, 32'h0);
    // Unmapped place answers with an error and zero
    xfer(1'b0, 8'h70, 32'h0);
    check("err_flag", {31'h0, err}, 32'h1);
    check("err_data", rd, 32'h0);
    xfer(1'b0, RESULT_BASE + 8'h02, 32'h0);
    check("misalign", {31'h0, err}, 32'h1);
    // Virtual signal carries the stored value unaltered
    period(0);
    check("out_data", 32'(udata[0]), 32'hA);
    // Too short a period is clamped; a longer one is kept
    // Host side: periods never shorter than the source's strobe spacing
    xfer(1'b1, RATE_BASE + 8'h08, 32'h3);
    xfer(1'b1, RATE_BASE + 8'h0C, 32'hC);
    period(2);
    period(2);
    check("rate_min", 32'(per), 32'(RMIN));
    period(3);
    period(3);
    check("rate_set", 32'(per), 32'hC);
    // Unit 0 as a minimum tracker, then following the raw input
    xfer(1'b1, CFG_BASE, 32'h00);
    u_pvd_src.send(0, 16'h0014);
    u_pvd_src.send(0, 16'h0002);
    rdchk("run_min0", RESULT_BASE, 32'h2);
    xfer(1'b1, CFG_BASE, 32'h10);
    u_pvd_src.send(0, 16'h0009);
    rdchk("follow0", RESULT_BASE, 32'h9);
    wrap_up();
  end
endmodule
